// ==== rtl/arc_regs.sv ====
// Purpose: Result, previous, accumulator, setpoint and error registers of
//          a 10-bit converter with computation, reached over APB.
// Assumes: conv_start, conv_done, conv_data and lpf_result come from the
//          converter core on pclk; presetn is the power-on reset.
// Notes:   Data registers have no reset and power up unknown.
`timescale 1ns/10ps
`include "arc_defs.svh"

module arc_regs #(
   parameter int RES_W  = 10,
   parameter int DATA_W = 16
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic              conv_start,
   input  wire logic              conv_done,
   input  wire logic [RES_W-1:0]  conv_data,
   input  wire logic [DATA_W-1:0] lpf_result,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr
);

   // Refuse widths other than the ten-bit result and sixteen-bit values.
   if (RES_W != 10 || DATA_W != 16) begin : g_bad_width
      $error("arc_regs supports only RES_W 10 and DATA_W 16.");
   end

   // Places a result in left or right justified sixteen-bit form.
   function automatic logic [15:0] arc_justify(
      input logic [9:0] res,
      input logic       fmt
   );
      arc_justify = fmt ? {6'h00, res} : {res, 6'h00};
   endfunction

   // Tells whether an address holds a register of this bank.
   function automatic logic arc_mapped(input logic [11:0] addr);
      unique case (addr)
         `ARC_OFF_RES_H, `ARC_OFF_RES_L, `ARC_OFF_PREV_H,
         `ARC_OFF_PREV_L, `ARC_OFF_ACC_H, `ARC_OFF_ACC_L,
         `ARC_OFF_STPT_H, `ARC_OFF_STPT_L, `ARC_OFF_ERR_H,
         `ARC_OFF_ERR_L, `ARC_OFF_CTRL, `ARC_OFF_FLT_H,
         `ARC_OFF_FLT_L: arc_mapped = 1'b1;
         default: arc_mapped = 1'b0;
      endcase
   endfunction

   arc_pkg::arc_ctrl_t ctrl;
   arc_pkg::arc_ctrl_t next_ctrl;
   logic [9:0]         result;
   logic [9:0]         next_result;
   logic [15:0]        prev;
   logic [15:0]        next_prev;
   logic [15:0]        acc;
   logic [15:0]        next_acc;
   logic [15:0]        stpt;
   logic [15:0]        next_stpt;
   logic [15:0]        calc_err;
   logic [15:0]        next_calc_err;
   logic [15:0]        filt;
   logic [15:0]        res_just;
   logic [31:0]        next_prdata;
   logic               next_pready;
   logic               next_pslverr;
   logic               wr_en;
   logic [7:0]         wbyte;
   logic               accum_mode;

   // A write takes effect at the edge that closes the access phase.
   assign wr_en = psel & penable & pready & pwrite;
   assign wbyte = pwdata[7:0];
   assign res_just = arc_justify(result, ctrl.fmt);

   // Accumulate, average and burst average all sum conversions.
   assign accum_mode = (ctrl.fmode == arc_pkg::ARC_FMD_ACC)
                     | (ctrl.fmode == arc_pkg::ARC_FMD_AVG)
                     | (ctrl.fmode == arc_pkg::ARC_FMD_BAVG);

   // Filter output is lpf_result in low-pass mode, else the accumulator shifted keeping its sign.
   always_comb begin
      if (ctrl.fmode == arc_pkg::ARC_FMD_LPF) begin
         filt = lpf_result;
      end else begin
         filt = 16'($signed(acc) >>> ctrl.shift);
      end
   end

   // Control word: only software changes it.
   always_comb begin
      next_ctrl = ctrl;
      if (wr_en && paddr == `ARC_OFF_CTRL) begin
         next_ctrl = arc_pkg::arc_ctrl_t'(pwdata[10:0]);
      end
   end

   // The control word is the only data state under reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= arc_pkg::arc_ctrl_t'(`ARC_CTRL_RESET);
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // Result: software writes land in the current layout, a finished
   // conversion overrides a write in the same cycle.
   always_comb begin
      next_result = result;
      if (wr_en && paddr == `ARC_OFF_RES_H) begin
         if (ctrl.fmt) begin
            next_result[9:8] = wbyte[1:0];
         end else begin
            next_result[9:2] = wbyte;
         end
      end else if (wr_en && paddr == `ARC_OFF_RES_L) begin
         if (ctrl.fmt) begin
            next_result[7:0] = wbyte;
         end else begin
            next_result[1:0] = wbyte[7:6];
         end
      end
      if (conv_done) begin
         next_result = conv_data;
      end
   end

   // Previous value is taken at every start and never written by software.
   always_comb begin
      next_prev = prev;
      if (conv_start) begin
         if (ctrl.psis) begin
            next_prev = filt;
         end else begin
            next_prev = res_just;
         end
      end
   end

   // Accumulator: software bytes; in the summing modes a finished conversion adds to the old value and overrides a write in the same cycle.
   always_comb begin
      next_acc = acc;
      if (wr_en && paddr == `ARC_OFF_ACC_H) begin
         next_acc[15:8] = wbyte;
      end else if (wr_en && paddr == `ARC_OFF_ACC_L) begin
         next_acc[7:0] = wbyte;
      end
      if (conv_done && accum_mode) begin
         next_acc = 16'(acc + {6'h00, conv_data});
      end
   end

   // Setpoint is a plain software register.
   always_comb begin
      next_stpt = stpt;
      if (wr_en && paddr == `ARC_OFF_STPT_H) begin
         next_stpt[15:8] = wbyte;
      end else if (wr_en && paddr == `ARC_OFF_STPT_L) begin
         next_stpt[7:0] = wbyte;
      end
   end

   // Error value follows the calculation mode one cycle behind its inputs.
   always_comb begin
      unique case (ctrl.calc)
         arc_pkg::ARC_CLC_RES_PREV: begin
            next_calc_err = 16'({6'h00, result} - prev);
         end
         arc_pkg::ARC_CLC_RES_STPT: begin
            next_calc_err = 16'({6'h00, result} - stpt);
         end
         arc_pkg::ARC_CLC_FLT_PREV: begin
            next_calc_err = 16'(filt - prev);
         end
         default: begin
            next_calc_err = 16'(filt - stpt);
         end
      endcase
   end

   // Data registers keep their contents across reset and power up unknown.
   always_ff @(posedge pclk) begin
      result   <= next_result;
      prev     <= next_prev;
      acc      <= next_acc;
      stpt     <= next_stpt;
      calc_err <= next_calc_err;
   end

   // Read data and answer are prepared in the setup cycle, so every
   // transfer finishes in its first access cycle.
   always_comb begin
      next_pready  = psel & ~penable;
      next_pslverr = psel & ~penable & ~arc_mapped(paddr);
      next_prdata  = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `ARC_OFF_RES_H:  next_prdata[7:0] = res_just[15:8];
            `ARC_OFF_RES_L:  next_prdata[7:0] = res_just[7:0];
            `ARC_OFF_PREV_H: next_prdata[7:0] = prev[15:8];
            `ARC_OFF_PREV_L: next_prdata[7:0] = prev[7:0];
            `ARC_OFF_ACC_H:  next_prdata[7:0] = acc[15:8];
            `ARC_OFF_ACC_L:  next_prdata[7:0] = acc[7:0];
            `ARC_OFF_STPT_H: next_prdata[7:0] = stpt[15:8];
            `ARC_OFF_STPT_L: next_prdata[7:0] = stpt[7:0];
            `ARC_OFF_ERR_H:  next_prdata[7:0] = calc_err[15:8];
            `ARC_OFF_ERR_L:  next_prdata[7:0] = calc_err[7:0];
            `ARC_OFF_CTRL:   next_prdata[10:0] = ctrl;
            `ARC_OFF_FLT_H:  next_prdata[7:0] = filt[15:8];
            `ARC_OFF_FLT_L:  next_prdata[7:0] = filt[7:0];
            default:         next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // Bus answer registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

endmodule

// ==== shared/arc_defs.svh ====
// Purpose: Offsets, field positions and reset values of the result bank.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Data sits in bits 7:0 of each word, bits 10:0 for the control word; the bits above read as zero.
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH

`define ARC_OFF_RES_H   12'h000
`define ARC_OFF_RES_L   12'h004
`define ARC_OFF_PREV_H  12'h008
`define ARC_OFF_PREV_L  12'h00C
`define ARC_OFF_ACC_H   12'h010
`define ARC_OFF_ACC_L   12'h014
`define ARC_OFF_STPT_H  12'h018
`define ARC_OFF_STPT_L  12'h01C
`define ARC_OFF_ERR_H   12'h020
`define ARC_OFF_ERR_L   12'h024
`define ARC_OFF_CTRL    12'h028
`define ARC_OFF_FLT_H   12'h02C
`define ARC_OFF_FLT_L   12'h030

`define ARC_CTRL_FMT    0
`define ARC_CTRL_PSIS   1
`define ARC_CTRL_SHF_LO 2
`define ARC_CTRL_CLC_LO 5
`define ARC_CTRL_FMD_LO 8
`define ARC_CTRL_RESET  11'h000

`endif

// ==== shared/arc_pkg.sv ====
// Purpose: Types shared by the result bank and its bench.
// Assumes: Field layout of the control word follows arc_defs.svh.
// Notes:   The control word is carried as one packed struct.
package arc_pkg;

   // Filter modes of the computation unit.
   typedef enum logic [2:0] {
      ARC_FMD_BASIC = 3'h0,
      ARC_FMD_ACC   = 3'h1,
      ARC_FMD_AVG   = 3'h2,
      ARC_FMD_BAVG  = 3'h3,
      ARC_FMD_LPF   = 3'h4
   } arc_fmode_t;

   // Calculation modes that choose the error value.
   typedef enum logic [2:0] {
      ARC_CLC_RES_PREV  = 3'h0,
      ARC_CLC_RES_STPT  = 3'h1,
      ARC_CLC_FLT_STPT  = 3'h2,
      ARC_CLC_FLT_PREV  = 3'h3
   } arc_calc_t;

   // Control word, msb first as it lies in the register.
   typedef struct packed {
      logic [2:0] fmode;
      logic [2:0] calc;
      logic [2:0] shift;
      logic       psis;
      logic       fmt;
   } arc_ctrl_t;

endpackage

// ==== dv/arc_chk.sv ====
// Purpose: Bus-side checks of the result bank.
// Assumes: Zero-wait APB slave on pclk.
// Notes:   Bound into every arc_regs instance.
`timescale 1ns/10ps
`include "arc_defs.svh"
module arc_chk #(
   parameter int RES_W  = 10,
   parameter int DATA_W = 16
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              conv_start,
   input wire logic              conv_done,
   input wire logic [RES_W-1:0]  conv_data,
   input wire logic [DATA_W-1:0] lpf_result,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr
);
   // All checks sample on pclk and rest during reset.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic setup;
   logic rd_ack;
   // Setup phase and a read answer, as the bus shows them.
   assign setup  = psel && !penable;
   assign rd_ack = pready && !pwrite;
   a_ready_next: assert property (setup |=> pready)
      else $error("pready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_ready_cause: assert property (pready |-> $past(setup))
      else $error("pready without setup");
   a_err_unmapped: assert property (setup && paddr > `ARC_OFF_FLT_L
      |=> pslverr && prdata == 32'h0000_0000) else $error("no refusal");
   a_err_mapped: assert property (setup && paddr <= `ARC_OFF_FLT_L &&
      paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped refused");
   a_byte_wide: assert property (rd_ack && paddr != `ARC_OFF_CTRL
      |-> prdata[31:8] == 24'h00_0000) else $error("bits above byte");
   a_ctrl_wide: assert property (rd_ack && paddr == `ARC_OFF_CTRL
      |-> prdata[31:11] == 21'h00_0000) else $error("bits above ctrl");
   a_reset_quiet: assert property ($rose(presetn) |-> !pready && !pslverr)
      else $error("answer right after reset");
   c_read: cover property (rd_ack);
   c_refuse: cover property (pslverr);
   c_conv: cover property (conv_done ##[1:20] rd_ack);
endmodule
bind arc_regs arc_chk #(.RES_W(RES_W), .DATA_W(DATA_W)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
   .lpf_result(lpf_result), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench of the result bank.
// Assumes: Zero-wait APB slave, 100 ns pclk.
// Notes:   Each access notes its answer; a monitor compares.
`timescale 1ns/10ps
`include "arc_defs.svh"
module tb_top;
   logic               pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic               pwrite = 0, conv_start = 0, conv_done = 0;
   logic [11:0]        paddr = '0;
   logic [31:0]        pwdata = '0, prdata;
   logic [9:0]         conv_data = '0, res;
   logic [15:0]        lpf_result = '0, acc, stpt, prv, e16;
   logic [15:0]        rnd = 16'h8BFE;
   logic               pready, pslverr;
   logic [33:0]        q[$];
   arc_pkg::arc_ctrl_t ctl = '0;
   int                 num_errors = 0, checked = 0, cyc = 0;
   arc_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .conv_start(conv_start), .conv_done(conv_done),
      .conv_data(conv_data), .lpf_result(lpf_result),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Clock, and a hang limit well above the run length.
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         $display("Error %0t: run timed out", $time);
         summarize();
      end
   end
   // The oldest note meets the answer once the answer has settled.
   always @(negedge pclk)
      if (pready === 1'b1 && q.size() > 0) cmp_resp(q.pop_front());
   task automatic cmp_resp(input logic [33:0] e);
      if (e[33]) begin
         checked++;
         if ({pslverr, prdata} !== e[32:0]) begin
            num_errors++;
            $display("Error %0t: got %h want %h", $time, {pslverr, prdata},
                     e[32:0]);
         end
      end
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Result as it lies in a register pair for the given layout.
   function automatic logic [15:0] jst(input logic f, input logic [9:0] r);
      return f ? {6'h0, r} : {r, 6'h0};
   endfunction
   function automatic logic [15:0] fltv();
      if (ctl.fmode == 3'h4) return lpf_result;
      return $signed(acc) >>> ctl.shift;
   endfunction
   // One APB transfer; the request holds until pready is seen.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [33:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      // Wait as long as the slave needs; only the bench timeout ends it.
      @(negedge pclk);
      while (pready !== 1'b1) begin
         @(negedge pclk);
      end
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h00_0000, d}, '0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [10:0] x);
      apb(1'b0, a, '0, {2'h2, 21'h00_0000, x});
   endtask
   task automatic rd16(input logic [11:0] a, input logic [15:0] v);
      rd(a, {3'h0, v[15:8]});
      rd(a + 12'h004, {3'h0, v[7:0]});
   endtask
   task automatic setc();
      apb(1'b1, `ARC_OFF_CTRL, {21'h00_0000, ctl}, '0);
   endtask
   // One core event; the model captures before it updates.
   task automatic conv(input logic s, input logic d);
      @(posedge pclk);
      conv_start <= s;
      conv_done <= d;
      conv_data <= rnd[9:0];
      if (d) lpf_result <= rnd;
      if (s) prv = ctl.psis ? fltv() : jst(ctl.fmt, res);
      if (d && ctl.fmode != 3'h0 && ctl.fmode < 3'h4)
         acc = acc + {6'h0, rnd[9:0]};
      if (d) res = rnd[9:0];
      @(posedge pclk);
      conv_start <= 1'b0;
      conv_done <= 1'b0;
      rnd = lfsr(rnd);
   endtask
   task automatic summarize();
      $display("Mismatches %0d, comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`ARC_OFF_CTRL, 11'h000);
      for (int w = 0; w < 2; w++)
         apb(w[0], 12'h040, '0, {2'h3, 32'h0000_0000});
      for (int f = 0; f < 2; f++) begin
         ctl.fmt = f[0];
         setc();
         conv(1'b0, 1'b1);
         rd16(`ARC_OFF_RES_H, jst(ctl.fmt, res));
         // Software writes land in the bits of the current layout.
         wr(`ARC_OFF_RES_H, rnd[15:8]);
         wr(`ARC_OFF_RES_L, rnd[7:0]);
         if (ctl.fmt) res = rnd[9:0];
         else res = {rnd[15:8], rnd[7:6]};
         rd16(`ARC_OFF_RES_H, jst(ctl.fmt, res));
         conv(1'b1, 1'b1);
         wr(`ARC_OFF_PREV_L, 8'h5A);
         rd16(`ARC_OFF_PREV_H, prv);
         rd16(`ARC_OFF_RES_H, jst(ctl.fmt, res));
      end
      wr(`ARC_OFF_ACC_H, 8'hFF);
      wr(`ARC_OFF_ACC_L, 8'hF0);
      acc = 16'hFFF0;
      rd16(`ARC_OFF_ACC_H, acc);
      for (int m = 1; m < 5; m++) begin
         ctl.fmode = m[2:0];
         ctl.shift = {m[1:0], 1'b0};
         ctl.psis = 1'b1;
         setc();
         conv(1'b0, 1'b1);
         rd16(`ARC_OFF_FLT_H, fltv());
         conv(1'b1, 1'b0);
         rd16(`ARC_OFF_PREV_H, prv);
      end
      wr(`ARC_OFF_STPT_H, 8'h01);
      wr(`ARC_OFF_STPT_L, 8'h23);
      stpt = 16'h0123;
      rd16(`ARC_OFF_STPT_H, stpt);
      wr(`ARC_OFF_ERR_H, 8'hFF);
      for (int c = 0; c < 4; c++) begin
         ctl.calc = c[2:0];
         setc();
         e16 = (c[1] ? fltv() : {6'h0, res}) - (c[0] ^ c[1] ? stpt : prv);
         rd16(`ARC_OFF_ERR_H, e16);
      end
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      ctl = '0;
      rd(`ARC_OFF_CTRL, 11'h000);
      rd16(`ARC_OFF_RES_H, jst(1'b0, res));
      rd16(`ARC_OFF_ACC_H, acc);
      rd16(`ARC_OFF_STPT_H, stpt);
      repeat (3) @(posedge pclk);
      summarize();
   end
endmodule
